// file: aux_io_pkg.sv
package aux_io_pkg;
    localparam int N_DIN  = 3;
    localparam int N_DOUT = 4;
    localparam int N_AIN  = 4;
    localparam int N_AOUT = 4;
    localparam int N_MEAS = 8;
    localparam int VAL_W  = 20;
    localparam int ACT_W  = 8;
    localparam int FILT_W = 24;
    localparam int MV_W   = 14;
    localparam int DAC_W  = 16;

    localparam int CLK_HZ             = 125_000_000;
    localparam int MS_PER_S           = 1000;
    localparam int SAMPLE_HZ          = 20;
    localparam int MS_CYCLES_DFLT     = CLK_HZ / MS_PER_S;
    localparam int SAMPLE_CYCLES_DFLT = CLK_HZ / SAMPLE_HZ;
    localparam int MS_CNT_W           = 17;
    localparam int SMP_CNT_W          = 23;

    localparam logic [MV_W-1:0]  RANGE_MIN_MV = 14'h03E8;
    localparam logic [MV_W-1:0]  RANGE_MAX_MV = 14'h2710;
    localparam logic [MV_W-1:0]  RANGE_RST_MV = 14'h2710;
    localparam logic [VAL_W-1:0] VAL_ZERO     = 20'h00000;
    localparam logic [VAL_W-1:0] FS_VOLT      = 20'h00BB8;
    localparam logic [VAL_W-1:0] FS_FREQ      = 20'h02EE0;
    localparam logic [VAL_W-1:0] MIN_FREQ     = 20'h00096;
    localparam logic [VAL_W-1:0] FS_CURR      = 20'h003E8;
    localparam logic [VAL_W-1:0] FS_KVA       = 20'h02710;
    localparam logic [VAL_W-1:0] FS_POW       = 20'h02710;
    localparam logic [VAL_W-1:0] MGAIN_VOLT   = 20'h00BB8;
    localparam logic [VAL_W-1:0] MGAIN_POW    = 20'h02710;
    localparam logic [DAC_W-1:0] DAC_FULL     = 16'hFFFF;
    localparam logic [DAC_W-1:0] DAC_ZERO     = 16'h0000;

    typedef enum logic [2:0] {
        FN_GP = 3'h0, FN_OUT_STATE = 3'h1, FN_PHASE_INDICATION_A = 3'h2, FN_FAULT = 3'h3,
        FN_TRANSIENT = 3'h4, FN_PROGRAM = 3'h5, FN_REMOTE = 3'h6, FN_XFMR = 3'h7
    } dout_func_e;

    typedef enum logic [2:0] {
        PRM_OFF = 3'h0, PRM_VOLT = 3'h1, PRM_FREQ = 3'h2,
        PRM_CURR = 3'h3, PRM_KVA = 3'h4, PRM_POW = 3'h5
    } ain_param_e;

    typedef enum logic [2:0] {
        MS_VRMS_A = 3'h0, MS_VRMS_B = 3'h1, MS_VRMS_C = 3'h2, MS_IRMS_A = 3'h3,
        MS_IRMS_B = 3'h4, MS_IRMS_C = 3'h5, MS_PWR_TOTAL = 3'h6, MS_FREQ = 3'h7
    } meas_sel_e;

    function automatic logic [VAL_W-1:0] param_fs(input ain_param_e p);
        unique case (p)
            PRM_VOLT: return FS_VOLT;
            PRM_FREQ: return FS_FREQ;
            PRM_CURR: return FS_CURR;
            PRM_KVA:  return FS_KVA;
            PRM_POW:  return FS_POW;
            default:  return VAL_ZERO;
        endcase
    endfunction : param_fs

    function automatic logic [VAL_W-1:0] param_min(input ain_param_e p);
        return (p == PRM_FREQ) ? MIN_FREQ : VAL_ZERO;
    endfunction : param_min
endpackage : aux_io_pkg

// file: din_filter.sv
`timescale 1ns/1ps
module din_filter
    import aux_io_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              pin,
    input  wire logic              ms_tick,
    input  wire logic [FILT_W-1:0] filter_ms,
    output logic                   level,
    output logic                   rise,
    output logic                   fall
);
    typedef struct packed {
        logic              s1;
        logic              s2;
        logic              lvl;
        logic [FILT_W-1:0] cnt;
        logic              rise;
        logic              fall;
    } flt_s;

    flt_s st_r;
    flt_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin;
        st_nxt.s2   = st_r.s1;
        st_nxt.rise = 1'b0;
        st_nxt.fall = 1'b0;
        if (st_r.s2 == st_r.lvl) begin
            st_nxt.cnt = '0;
        end else if (filter_ms == '0 || (ms_tick && st_r.cnt >= filter_ms)) begin
            // one extra tick so the level has stood a full filter time whatever the tick phase
            st_nxt.lvl  = st_r.s2;
            st_nxt.rise = st_r.s2;
            st_nxt.fall = !st_r.s2;
            st_nxt.cnt  = '0;
        end else if (ms_tick) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
        if (reset) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    assign level = st_r.lvl;
    assign rise  = st_r.rise;
    assign fall  = st_r.fall;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    zero_pass_a: assert property ((filter_ms == '0 && st_r.s2 != st_r.lvl) |=> (rise || fall))
        else $error("zero filter edge not passed");
    glitch_block_a: assert property ((rise || fall) |->
        ($past(filter_ms) == '0 || ($past(st_r.cnt) >= $past(filter_ms) && $past(ms_tick))))
        else $error("edge before filter time");
endmodule : din_filter

// file: aux_user_io_mapper.sv
`timescale 1ns/1ps
module aux_user_io_mapper
    import aux_io_pkg::*;
#(
    parameter int MS_CYCLES     = MS_CYCLES_DFLT,
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DFLT
) (
    input  wire logic                                sys_clk,
    input  wire logic                                reset,
    input  wire logic                                user_digital_input_one,
    input  wire logic                                user_digital_input_two,
    input  wire logic                                user_digital_input_three,
    input  wire logic [aux_io_pkg::N_DIN-1:0]        din_cfg_we,
    input  wire logic [aux_io_pkg::ACT_W-1:0]        din_rise_data,
    input  wire logic [aux_io_pkg::ACT_W-1:0]        din_fall_data,
    input  wire logic [aux_io_pkg::FILT_W-1:0]       din_filter_data,
    output logic [aux_io_pkg::N_DIN-1:0]             din_state,
    output logic [aux_io_pkg::N_DIN-1:0]             din_action_strobe,
    output logic [aux_io_pkg::N_DIN-1:0][7:0]        din_action_code,
    input  wire logic                                power_output_enabled,
    input  wire logic                                single_phase_phase_indication_a,
    input  wire logic                                fault_active,
    input  wire logic                                transient_active,
    input  wire logic                                program_running,
    input  wire logic                                remote_control,
    input  wire logic                                transformer_coupled,
    input  wire logic [aux_io_pkg::N_DOUT-1:0]       dout_cfg_we,
    input  wire aux_io_pkg::dout_func_e              dout_func_data,
    input  wire logic                                dout_inv_data,
    input  wire logic                                dout_gp_we,
    input  wire logic [aux_io_pkg::N_DOUT-1:0]       dout_gp_data,
    output logic                                     user_digital_output_one,
    output logic                                     user_digital_output_two,
    output logic                                     user_digital_output_three,
    output logic                                     relay_drive_output_a_oe,
    output logic                                     user_digital_output_four,
    output logic                                     relay_drive_output_b_oe,
    input  wire logic [aux_io_pkg::N_AIN-1:0][13:0]  ain_level_mv,
    input  wire logic [aux_io_pkg::N_AIN-1:0]        ain_cfg_we,
    input  wire aux_io_pkg::ain_param_e              ain_param_data,
    input  wire logic [1:0]                          ain_phase_data,
    input  wire logic [aux_io_pkg::MV_W-1:0]         ain_range_data,
    input  wire logic [aux_io_pkg::N_AIN-1:0]        ain_gain_we,
    input  wire logic [aux_io_pkg::N_AIN-1:0]        ain_offset_we,
    input  wire logic [aux_io_pkg::VAL_W-1:0]        ain_cal_data,
    output logic [aux_io_pkg::N_AIN-1:0][19:0]       ain_setpoint,
    output logic [aux_io_pkg::N_AIN-1:0]             ain_setpoint_strobe,
    output aux_io_pkg::ain_param_e [3:0]             ain_target_param,
    output logic [aux_io_pkg::N_AIN-1:0][1:0]        ain_target_phase,
    input  wire logic [aux_io_pkg::N_MEAS-1:0][19:0] meas_value,
    input  wire logic [aux_io_pkg::N_AOUT-1:0]       aout_cfg_we,
    input  wire aux_io_pkg::meas_sel_e               aout_sel_data,
    input  wire logic [aux_io_pkg::N_AOUT-1:0]       aout_gain_we,
    input  wire logic [aux_io_pkg::N_AOUT-1:0]       aout_offset_we,
    input  wire logic [aux_io_pkg::VAL_W-1:0]        aout_cal_data,
    output logic [aux_io_pkg::DAC_W-1:0]             analog_monitor_out_one,
    output logic [aux_io_pkg::DAC_W-1:0]             analog_monitor_out_two,
    output logic [aux_io_pkg::DAC_W-1:0]             analog_monitor_out_three,
    output logic [aux_io_pkg::DAC_W-1:0]             analog_monitor_out_four
);
    import aux_io_pkg::*;

    typedef struct packed {
        logic [MS_CNT_W-1:0]             ms_cnt;
        logic                            ms_tick;
        logic [SMP_CNT_W-1:0]            smp_cnt;
        logic                            smp_tick;
        logic [N_DIN-1:0][ACT_W-1:0]     rise_act;
        logic [N_DIN-1:0][ACT_W-1:0]     fall_act;
        logic [N_DIN-1:0][FILT_W-1:0]    filt;
        logic [N_DIN-1:0]                act_stb;
        logic [N_DIN-1:0][ACT_W-1:0]     act_code;
        dout_func_e [N_DOUT-1:0]         dfunc;
        logic [N_DOUT-1:0]               dinv;
        logic [N_DOUT-1:0]               dgp;
        logic [N_DOUT-1:0]               dout;
        logic [1:0]                      od_lvl;
        ain_param_e [N_AIN-1:0]          aprm;
        logic [N_AIN-1:0][1:0]           aphase;
        logic [N_AIN-1:0][MV_W-1:0]      arange;
        logic [N_AIN-1:0][VAL_W-1:0]     again;
        logic [N_AIN-1:0][VAL_W-1:0]     aoff;
        logic [N_AIN-1:0][VAL_W-1:0]     aset;
        logic [N_AIN-1:0]                astb;
        meas_sel_e [N_AOUT-1:0]          msel;
        logic [N_AOUT-1:0][VAL_W-1:0]    mgain;
        logic [N_AOUT-1:0][VAL_W-1:0]    moff;
        logic [N_AOUT-1:0][DAC_W-1:0]    aout;
    } io_s;

    io_s               st_r;
    io_s               st_nxt;
    logic [N_DIN-1:0]  din_pin;
    logic [N_DIN-1:0]  din_lvl;
    logic [N_DIN-1:0]  din_rise;
    logic [N_DIN-1:0]  din_fall;

    function automatic logic dout_cond(input dout_func_e f, input logic gp);
        logic r;
        r = 1'b0;
        unique case (f)
            FN_GP:        r = gp;
            FN_OUT_STATE: r = power_output_enabled;
            FN_PHASE_INDICATION_A:      r = single_phase_phase_indication_a;
            FN_FAULT:     r = fault_active;
            FN_TRANSIENT: r = transient_active;
            FN_PROGRAM:   r = program_running;
            FN_REMOTE:    r = remote_control;
            FN_XFMR:      r = transformer_coupled;
        endcase
        return r;
    endfunction : dout_cond

    // the divide is deep and its operands can change the cycle before the 20 Hz sample tick, so it must settle within one sys_clk period
    function automatic logic [VAL_W-1:0] ain_scale(input logic [VAL_W-1:0] g,
                                                   input logic [VAL_W-1:0] o,
                                                   input logic [MV_W-1:0]  lv,
                                                   input logic [MV_W-1:0]  rg,
                                                   input ain_param_e       p);
        logic signed [36:0] span;
        logic signed [36:0] res;
        logic signed [36:0] lo;
        logic signed [36:0] hi;
        logic [MV_W-1:0]    v;
        v    = (lv > rg) ? rg : lv;
        span = 37'($signed(g)) - 37'($signed(o));
        res  = 37'($signed(o)) + (span * $signed({23'h000000, v})) / $signed({23'h000000, rg});
        lo   = 37'($signed(param_min(p)));
        hi   = 37'($signed(param_fs(p)));
        if (res < lo) begin
            res = lo;
        end else if (res > hi) begin
            res = hi;
        end
        return res[VAL_W-1:0];
    endfunction : ain_scale

    function automatic logic [DAC_W-1:0] aout_scale(input logic [VAL_W-1:0] m,
                                                    input logic [VAL_W-1:0] g,
                                                    input logic [VAL_W-1:0] o);
        logic signed [37:0] num;
        logic signed [37:0] q;
        num = 38'($signed(m)) - 38'($signed(o));
        if (num <= 0) begin
            return DAC_ZERO;
        end
        if ($signed(g) <= 0) begin
            return DAC_FULL;
        end
        q = (num * 38'(DAC_FULL)) / 38'($signed(g));
        return (q > 38'(DAC_FULL)) ? DAC_FULL : q[DAC_W-1:0];
    endfunction : aout_scale

    assign din_pin = {user_digital_input_three, user_digital_input_two, user_digital_input_one};

    for (genvar i = 0; i < N_DIN; i++) begin : g_din
        din_filter u_filter (
            .sys_clk   (sys_clk),
            .reset     (reset),
            .pin       (din_pin[i]),
            .ms_tick   (st_r.ms_tick),
            .filter_ms (st_r.filt[i]),
            .level     (din_lvl[i]),
            .rise      (din_rise[i]),
            .fall      (din_fall[i])
        );
    end

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ms_tick  = 1'b0;
        st_nxt.smp_tick = 1'b0;
        st_nxt.act_stb  = '0;
        st_nxt.astb     = '0;
        st_nxt.od_lvl   = 2'h0;
        if (st_r.ms_cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
            st_nxt.ms_cnt  = '0;
            st_nxt.ms_tick = 1'b1;
        end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 1'b1;
        end
        if (st_r.smp_cnt == SMP_CNT_W'(SAMPLE_CYCLES - 1)) begin
            st_nxt.smp_cnt  = '0;
            st_nxt.smp_tick = 1'b1;
        end else begin
            st_nxt.smp_cnt = st_r.smp_cnt + 1'b1;
        end
        for (int i = 0; i < N_DIN; i++) begin
            if (din_cfg_we[i]) begin
                st_nxt.rise_act[i] = din_rise_data;
                st_nxt.fall_act[i] = din_fall_data;
                st_nxt.filt[i]     = din_filter_data;
            end
            if (din_rise[i]) begin
                st_nxt.act_stb[i]  = 1'b1;
                st_nxt.act_code[i] = st_r.rise_act[i];
            end else if (din_fall[i]) begin
                st_nxt.act_stb[i]  = 1'b1;
                st_nxt.act_code[i] = st_r.fall_act[i];
            end
        end
        if (dout_gp_we) begin
            st_nxt.dgp = dout_gp_data;
        end
        for (int i = 0; i < N_DOUT; i++) begin
            if (dout_cfg_we[i]) begin
                st_nxt.dfunc[i] = dout_func_data;
                st_nxt.dinv[i]  = dout_inv_data;
            end
            // on outputs three and four a one means FET on, which pulls the pin low
            st_nxt.dout[i] = dout_cond(st_r.dfunc[i], st_r.dgp[i]) ^ st_r.dinv[i];
        end
        for (int i = 0; i < N_AIN; i++) begin
            if (ain_gain_we[i]) begin
                st_nxt.again[i] = ain_cal_data;
            end
            if (ain_offset_we[i]) begin
                st_nxt.aoff[i] = ain_cal_data;
            end
            if (ain_cfg_we[i]) begin
                st_nxt.aprm[i]   = ain_param_data;
                st_nxt.aphase[i] = ain_phase_data;
                st_nxt.arange[i] = (ain_range_data < RANGE_MIN_MV) ? RANGE_MIN_MV :
                                   (ain_range_data > RANGE_MAX_MV) ? RANGE_MAX_MV :
                                   ain_range_data;
                if (ain_param_data != st_r.aprm[i]) begin
                    // units change with the parameter, so stale scaling would be meaningless
                    st_nxt.again[i] = param_fs(ain_param_data);
                    st_nxt.aoff[i]  = VAL_ZERO;
                end
            end
            if (st_r.smp_tick && st_r.aprm[i] != PRM_OFF) begin
                st_nxt.aset[i] = ain_scale(st_r.again[i], st_r.aoff[i], ain_level_mv[i],
                                           st_r.arange[i], st_r.aprm[i]);
                st_nxt.astb[i] = 1'b1;
            end
        end
        for (int i = 0; i < N_AOUT; i++) begin
            if (aout_cfg_we[i]) begin
                st_nxt.msel[i] = aout_sel_data;
            end
            if (aout_gain_we[i]) begin
                st_nxt.mgain[i] = aout_cal_data;
            end
            if (aout_offset_we[i]) begin
                st_nxt.moff[i] = aout_cal_data;
            end
            st_nxt.aout[i] = aout_scale(meas_value[st_r.msel[i]], st_r.mgain[i], st_r.moff[i]);
        end
        if (reset) begin
            st_nxt        = '0;
            for (int i = 0; i < N_DOUT; i++) begin
                st_nxt.dfunc[i] = FN_GP;
            end
            for (int i = 0; i < N_AIN; i++) begin
                st_nxt.aprm[i] = PRM_OFF;
            end
            st_nxt.arange = {N_AIN{RANGE_RST_MV}};
            st_nxt.msel[0] = MS_VRMS_A;
            st_nxt.msel[1] = MS_VRMS_B;
            st_nxt.msel[2] = MS_VRMS_C;
            st_nxt.msel[3] = MS_PWR_TOTAL;
            st_nxt.mgain  = {MGAIN_POW, MGAIN_VOLT, MGAIN_VOLT, MGAIN_VOLT};
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    assign din_state                 = din_lvl;
    assign din_action_strobe         = st_r.act_stb;
    assign din_action_code           = st_r.act_code;
    assign user_digital_output_one   = st_r.dout[0];
    assign user_digital_output_two   = st_r.dout[1];
    assign user_digital_output_three = st_r.od_lvl[0];
    assign relay_drive_output_a_oe   = st_r.dout[2];
    assign user_digital_output_four  = st_r.od_lvl[1];
    assign relay_drive_output_b_oe   = st_r.dout[3];
    assign ain_setpoint              = st_r.aset;
    assign ain_setpoint_strobe       = st_r.astb;
    assign ain_target_param          = st_r.aprm;
    assign ain_target_phase          = st_r.aphase;
    assign analog_monitor_out_one    = st_r.aout[0];
    assign analog_monitor_out_two    = st_r.aout[1];
    assign analog_monitor_out_three  = st_r.aout[2];
    assign analog_monitor_out_four   = st_r.aout[3];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    gp_level_a: assert property ((st_r.dfunc[0] == FN_GP && !st_r.dinv[0])
        |=> user_digital_output_one == $past(st_r.dgp[0]))
        else $error("gp output not at written level");
    fault_map_a: assert property ((st_r.dfunc[0] == FN_FAULT && !st_r.dinv[0])
        |=> user_digital_output_one == $past(fault_active))
        else $error("fault output wrong");
    invert_map_a: assert property ((st_r.dfunc[1] == FN_REMOTE && st_r.dinv[1])
        |=> user_digital_output_two == !$past(remote_control))
        else $error("inverted output wrong");
    relay_fet_a: assert property ((st_r.dfunc[2] == FN_OUT_STATE && !st_r.dinv[2] &&
        power_output_enabled) |=> relay_drive_output_a_oe && !user_digital_output_three)
        else $error("relay FET not on");
    ain_off_a: assert property ((st_r.aprm[0] == PRM_OFF) |-> !ain_setpoint_strobe[0])
        else $error("disabled input updated");
    sample_tick_a: assert property (ain_setpoint_strobe[0] |-> $past(st_r.smp_tick))
        else $error("update off the sample tick");
    sample_gap_a: assert property (ain_setpoint_strobe[0] |=> !ain_setpoint_strobe[0] [*8])
        else $error("updates too close");
    prm_default_a: assert property ((ain_cfg_we[0] && ain_param_data != st_r.aprm[0])
        |=> st_r.aoff[0] == VAL_ZERO && st_r.again[0] == param_fs(st_r.aprm[0]))
        else $error("scaling not reset on parameter change");
    ain_clamp_a: assert property (ain_setpoint_strobe[0] |->
        ($signed(ain_setpoint[0]) >= $signed(param_min($past(st_r.aprm[0]))) &&
         $signed(ain_setpoint[0]) <= $signed(param_fs($past(st_r.aprm[0])))))
        else $error("set-point outside limits");
    aout_floor_a: assert property ((!aout_cfg_we[0] && !aout_offset_we[0] &&
        $signed(meas_value[st_r.msel[0]]) <= $signed(st_r.moff[0]))
        |=> analog_monitor_out_one == DAC_ZERO)
        else $error("monitor below offset not zero");

    ain_update_c: cover property (ain_setpoint_strobe[0] && st_r.aprm[0] == PRM_VOLT);
    din_action_c: cover property (din_action_strobe[0] ##[1:1000] din_action_strobe[0]);
    relay_on_c:   cover property ($rose(relay_drive_output_b_oe));
    aout_full_c:  cover property (analog_monitor_out_four == DAC_FULL);
endmodule : aux_user_io_mapper

// file: aux_plc_model.sv
`timescale 1ns/1ps
module aux_plc_model (
    input  wire logic  relay_a_on,
    input  wire logic  relay_b_on,
    output logic [2:0] plc_pins,
    output wire logic  relay_pin_a,
    output wire logic  relay_pin_b
);
    initial plc_pins = 3'h0;
    // pull-up wins unless the fet sinks the line
    assign relay_pin_a = relay_a_on ? 1'b0 : 1'b1;
    assign relay_pin_b = relay_b_on ? 1'b0 : 1'b1;
    task automatic set_pins(input logic [2:0] v);
        plc_pins = v;
    endtask : set_pins
endmodule : aux_plc_model

// file: aux_user_io_mapper_tb_top.sv
`timescale 1ns/1ps
module aux_user_io_mapper_tb_top;
    import aux_io_pkg::*;
    logic sys_clk = 0, reset = 1, dout_inv_data = 0, dout_gp_we = 0, pin_a, pin_b;
    logic user_digital_input_one, user_digital_input_two, user_digital_input_three;
    logic user_digital_output_one, user_digital_output_two, user_digital_output_three;
    logic user_digital_output_four, relay_drive_output_a_oe, relay_drive_output_b_oe;
    wire logic power_output_enabled, single_phase_phase_indication_a, fault_active, transient_active;
    wire logic program_running, remote_control, transformer_coupled;
    logic [2:0] din_cfg_we = 0, din_state, din_action_strobe, pins;
    logic [7:0] din_rise_data = 0, din_fall_data = 0, stb;
    logic [6:0] st = 0;
    logic [23:0] din_filter_data = 0;
    logic [2:0][7:0] din_action_code;
    logic [3:0] dout_cfg_we = 0, dout_gp_data = 0, ain_cfg_we = 0, ain_gain_we = 0;
    logic [3:0] ain_offset_we = 0, ain_setpoint_strobe, aout_cfg_we = 0;
    logic [3:0] aout_gain_we = 0, aout_offset_we = 0;
    dout_func_e dout_func_data = FN_GP;
    ain_param_e ain_param_data = PRM_OFF;
    ain_param_e [3:0] ain_target_param;
    meas_sel_e aout_sel_data = MS_VRMS_A;
    logic [1:0] ain_phase_data = 0;
    logic [3:0][1:0] ain_target_phase;
    logic [13:0] ain_range_data = 14'h2710;
    logic [3:0][13:0] ain_level_mv = 0;
    logic [19:0] ain_cal_data = 0, aout_cal_data = 0;
    logic [3:0][19:0] ain_setpoint;
    logic [7:0][19:0] meas_value = 0;
    logic [15:0] analog_monitor_out_one, analog_monitor_out_two;
    logic [15:0] analog_monitor_out_three, analog_monitor_out_four;
    int error_cnt = 0, n_checks = 0;
    bit ok;
    assign {transformer_coupled, remote_control, program_running, transient_active,
            fault_active, single_phase_phase_indication_a, power_output_enabled} = st;
    assign {user_digital_input_three, user_digital_input_two, user_digital_input_one} = pins;
    assign stb = {ain_setpoint_strobe, 1'b0, din_action_strobe};
    aux_user_io_mapper #(.MS_CYCLES(10), .SAMPLE_CYCLES(50)) uut (.*);
    aux_plc_model plc (.relay_a_on(relay_drive_output_a_oe), .relay_b_on(relay_drive_output_b_oe),
                       .plc_pins(pins), .relay_pin_a(pin_a), .relay_pin_b(pin_b));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic step(input int n = 1);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : step
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // bounded wait on one strobe; a missing required strobe ends the run
    task automatic wt(input int i, input int n, input bit must);
        ok = 0;
        for (int k = 0; k < n && !ok; k++) begin
            step();
            ok = (stb[i] === 1'b1);
        end
        if (must && !ok) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wt
    task automatic dcfg(input logic [3:0] m, input dout_func_e f, input logic i);
        dout_cfg_we = m;
        dout_func_data = f;
        dout_inv_data = i;
        step();
        dout_cfg_we = 0;
    endtask : dcfg
    task automatic acfg(input ain_param_e p);
        ain_cfg_we = 4'h1;
        ain_param_data = p;
        step();
        ain_cfg_we = 0;
        wt(4, 200, 1);
        wt(4, 200, 1);
    endtask : acfg
    task automatic t_dout;
        for (int f = 1; f < 8; f++) begin
            dcfg(4'h1, dout_func_e'(f), 1'b0);
            st = 7'h01 << (f - 1);
            step(2);
            chk("dout one on", 20'h1, user_digital_output_one);
            st = 0;
            step(2);
            chk("dout one off", 20'h0, user_digital_output_one);
        end
        dcfg(4'h1, FN_GP, 1'b1);
        step(2);
        chk("dout one inv", 20'h1, user_digital_output_one);
        dcfg(4'h2, FN_REMOTE, 1'b1);
        st = 7'h20;
        step(2);
        chk("dout two inv", 20'h0, user_digital_output_two);
        dcfg(4'h4, FN_OUT_STATE, 1'b0);
        st = 7'h01;
        dout_gp_data = 4'h8;
        dout_gp_we = 1;
        step();
        dout_gp_we = 0;
        step(2);
        chk("relay a", 20'h0, {pin_a, user_digital_output_three});
        chk("relay b", 20'h0, {pin_b, user_digital_output_four});
        $display("test dout done");
    endtask : t_dout
    task automatic t_din;
        din_cfg_we = 3'h2;
        din_rise_data = 8'hA5;
        din_fall_data = 8'h5A;
        step();
        din_cfg_we = 0;
        plc.set_pins(3'h2);
        wt(1, 20, 1);
        chk("rise code", 20'hA5, din_action_code[1]);
        plc.set_pins(3'h0);
        wt(1, 20, 1);
        chk("fall code", 20'h5A, din_action_code[1]);
        din_filter_data = 24'h2;
        din_cfg_we = 3'h2;
        step();
        din_cfg_we = 0;
        plc.set_pins(3'h2);
        step(5);
        plc.set_pins(3'h0);
        wt(1, 80, 0);
        chk("glitch", 20'h0, ok);
        plc.set_pins(3'h2);
        wt(1, 80, 1);
        chk("filtered level", 20'h1, din_state[1]);
        $display("test din done");
    endtask : t_din
    task automatic t_ain;
        chk("ain off", 20'h0, ain_target_param[0]);
        wt(4, 120, 0);
        chk("ain idle", 20'h0, ok);
        ain_level_mv[0] = 14'h2710;
        acfg(PRM_VOLT);
        chk("volt fs", 20'h00BB8, ain_setpoint[0]);
        ain_level_mv[0] = 14'h0;
        acfg(PRM_FREQ);
        chk("freq zero", 20'h00096, ain_setpoint[0]);
        ain_range_data = 14'h1388;
        ain_phase_data = 2'h2;
        acfg(PRM_VOLT);
        chk("ain phase", 20'h2, ain_target_phase[0]);
        ain_cal_data = 20'h005DC;
        ain_gain_we = 4'h1;
        step();
        ain_cal_data = 20'h001F4;
        ain_gain_we = 0;
        ain_offset_we = 4'h1;
        step();
        ain_offset_we = 0;
        ain_level_mv[0] = 14'h09C4;
        wt(4, 120, 1);
        wt(4, 120, 1);
        chk("ain mid", 20'h003E8, ain_setpoint[0]);
        $display("test ain done");
    endtask : t_ain
    task automatic t_aout;
        meas_value[0] = 20'h00BB8;
        meas_value[1] = 20'h005DC;
        meas_value[2] = 20'h00BB8;
        meas_value[6] = 20'h02710;
        step(3);
        chk("mon one fs", 20'hFFFF, analog_monitor_out_one);
        chk("mon two half", 20'h7FFF, analog_monitor_out_two);
        chk("mon three fs", 20'hFFFF, analog_monitor_out_three);
        chk("mon four fs", 20'hFFFF, analog_monitor_out_four);
        meas_value[0] = 20'h005DC;
        meas_value[3] = 20'h005DC;
        aout_sel_data = MS_IRMS_A;
        aout_cfg_we = 4'h8;
        step();
        aout_cfg_we = 0;
        step(2);
        chk("mon one half", 20'h7FFF, analog_monitor_out_one);
        chk("mon four sel", 20'h2666, analog_monitor_out_four);
        aout_cal_data = 20'h001F4;
        aout_offset_we = 4'h1;
        step();
        aout_cal_data = 20'h005DC;
        aout_offset_we = 0;
        aout_gain_we = 4'h1;
        step();
        aout_gain_we = 0;
        step(2);
        chk("mon one scaled", 20'hAAAA, analog_monitor_out_one);
        $display("test aout done");
    endtask : t_aout
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        step(8);
        reset = 0;
        step(2);
        t_aout();
        t_ain();
        t_dout();
        t_din();
        wrap_up();
    end
endmodule : aux_user_io_mapper_tb_top
